// ### design/ring_pkg.sv
// Purpose: Shared constants and carriers for the ring cyclic telegram slave
// Assumes: 125 MHz clock, APB register access
// Notes: Times in microseconds, lengths in bytes
package ring_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int POS_CLK_A_US = 250;
  localparam int POS_CLK_B_US = 500;
  localparam int MAX_CYCLE_US = 65000;
  localparam int SYNC_TIMEOUT_CYCLES_DEF = 2;
  localparam int BAUD_WIN_US = 1;
  localparam logic [15:0] BAUD_WIN_CYC = 16'(BAUD_WIN_US * CLK_MHZ);
  // Edge counts per window for 4/8/16 MBaud, lower bounds
  localparam logic [15:0] BAUD_TH_4 = 16'h0003;
  localparam logic [15:0] BAUD_TH_8 = 16'h0006;
  localparam logic [15:0] BAUD_TH_16 = 16'h000c;
  // ----------------------------------------
  // Length limits
  // ----------------------------------------
  localparam logic [7:0] MAX_DATA_LONG = 8'h30;
  localparam logic [7:0] MAX_DATA_SHORT = 8'h18;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CYCLE = 8'h04;
  localparam logic [7:0] OFS_SLOT = 8'h08;
  localparam logic [7:0] OFS_MDT = 8'h0c;
  localparam logic [7:0] OFS_LIST = 8'h10;
  localparam logic [7:0] OFS_ADDR = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_ERR = 8'h1c;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_CABLE_LSB = 0;
  localparam int CTRL_POS500_BIT = 8;
  localparam int MCW_ENABLE_BIT = 15;
  localparam int ERR_W = 17;
  // Error bit indices
  localparam int E_MDT_ODD = 0;
  localparam int E_SLOT = 1;
  localparam int E_MDT_END = 2;
  localparam int E_T3_IN = 3;
  localparam int E_REC = 4;
  localparam int E_T4 = 5;
  localparam int E_CYC = 6;
  localparam int E_RATIO = 7;
  localparam int E_MDT_LEN = 8;
  localparam int E_AT_LEN = 9;
  localparam int E_MDT_IDN = 10;
  localparam int E_AT_IDN = 11;
  localparam int E_SYNC = 12;
  localparam int E_RTD = 13;
  localparam int E_PH_INV = 14;
  localparam int E_PH_UP = 15;
  localparam int E_PH_NRDY = 16;
  localparam logic [31:0] RST_CYCLE = 32'h00fa_00fa;

  typedef enum logic [1:0] {BAUD_2, BAUD_4, BAUD_8, BAUD_16} baud_e;

  // Per-cycle telegram events from the ring receiver
  typedef struct packed {
    logic sync_seen;
    logic [2:0] phase;
    logic mdt_seen;
    logic [15:0] mcw;
    logic list_bad_mdt;
    logic list_bad_at;
  } telegram_s;
endpackage

// ### design/ring_cyclic_telegram_slave.sv
// Purpose: Cyclic telegram timing, checks and faults for a ring drive slave
// Assumes: Receiver decodes telegrams into telegram_s pulses
// Notes: Times in microseconds; sticky errors clear by writing one
`timescale 1ns/10ps
module ring_cyclic_telegram_slave import ring_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Ring side
  input wire logic rx_i,
  input wire telegram_s tel_i,
  input wire logic drive_ready_i,
  // Drive side
  output logic [1:0] tx_power_o,
  output logic [7:0] drive_addr_o,
  output logic [2:0] phase_o,
  output logic cmd_apply_o,
  output logic fb_sample_o,
  output logic enable_req_o,
  output logic distortion_indicator_o
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] ctrl_reg, cycle_reg, slot_reg, mdt_reg, list_reg;
  logic [7:0] addr_reg, addr_act_reg;
  logic [ERR_W-1:0] err_reg, err_set;
  baud_e baud_reg;
  logic [2:0] phase_reg;
  logic [15:0] comm_cycle_time, control_cycle_time;
  logic [15:0] t2, t3, t4, min_feedback_acquisition_time;
  logic [7:0] mdt_len, rec_pos, rec_len, mdt_data_len, at_data_len, lim;
  logic [15:0] pos_us;
  logic wr, rd_ok;

  assign comm_cycle_time = cycle_reg[15:0];
  assign control_cycle_time = cycle_reg[31:16];
  assign t2 = slot_reg[15:0];
  assign t3 = slot_reg[31:16];
  assign t4 = mdt_reg[31:16];
  assign min_feedback_acquisition_time = {8'h00, list_reg[31:24]};
  assign mdt_len = mdt_reg[7:0];
  assign rec_pos = mdt_reg[15:8];
  assign rec_len = list_reg[23:16];
  assign mdt_data_len = list_reg[7:0];
  assign at_data_len = list_reg[15:8];
  assign pos_us = ctrl_reg[CTRL_POS500_BIT] ? 16'(POS_CLK_B_US) : 16'(POS_CLK_A_US);

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign pready_o = 1'b1;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd_ok = paddr_i[1:0] == 2'b00 && paddr_i <= OFS_ERR;
  assign pslverr_o = psel_i && penable_i && !rd_ok;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= '0;
      cycle_reg <= RST_CYCLE;
      slot_reg <= '0;
      mdt_reg <= '0;
      list_reg <= '0;
      addr_reg <= '0;
    end else if (wr) begin
      case (paddr_i)
        OFS_CTRL: ctrl_reg <= pwdata_i;
        OFS_CYCLE: cycle_reg <= pwdata_i;
        OFS_SLOT: slot_reg <= pwdata_i;
        OFS_MDT: mdt_reg <= pwdata_i;
        OFS_LIST: list_reg <= pwdata_i;
        OFS_ADDR: addr_reg <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= '0;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        OFS_CTRL: prdata_o <= ctrl_reg;
        OFS_CYCLE: prdata_o <= cycle_reg;
        OFS_SLOT: prdata_o <= slot_reg;
        OFS_MDT: prdata_o <= mdt_reg;
        OFS_LIST: prdata_o <= list_reg;
        OFS_ADDR: prdata_o <= {24'h0, addr_reg};
        OFS_STATUS: prdata_o <= {16'h0, addr_act_reg, 3'h0, phase_reg, baud_reg};
        OFS_ERR: prdata_o <= {15'h0, err_reg};
        default: prdata_o <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Configuration checks
  // ----------------------------------------
  function automatic logic gt16(input logic [15:0] a, input logic [15:0] b);
    return a > b;
  endfunction

  logic [ERR_W-1:0] cfg_err;
  logic [16:0] mdt_end;
  logic [8:0] rec_end;
  assign lim = (comm_cycle_time == pos_us) ? MAX_DATA_SHORT : MAX_DATA_LONG;
  assign mdt_end = 17'(t2) + 17'(mdt_len);
  assign rec_end = 9'(rec_pos) + 9'(rec_len) - 9'h001;
  always_comb begin
    cfg_err = '0;
    cfg_err[E_MDT_ODD] = mdt_len[0];
    cfg_err[E_SLOT] = gt16(t2, comm_cycle_time) || gt16(t3, comm_cycle_time)
                      || gt16(t4, comm_cycle_time);
    cfg_err[E_MDT_END] = mdt_end > 17'(comm_cycle_time);
    cfg_err[E_T3_IN] = t3 >= t2 && 17'(t3) < mdt_end;
    cfg_err[E_REC] = rec_len != 8'h00 && rec_end > 9'(mdt_len);
    cfg_err[E_T4] = gt16(t4, comm_cycle_time - min_feedback_acquisition_time);
    cfg_err[E_CYC] = comm_cycle_time == 16'h0 || comm_cycle_time % pos_us != 16'h0
                     || 32'(comm_cycle_time) > 32'(MAX_CYCLE_US)
                     || control_cycle_time == 16'h0;
    cfg_err[E_RATIO] = control_cycle_time % comm_cycle_time != 16'h0
                       || gt16(comm_cycle_time, control_cycle_time);
    cfg_err[E_MDT_LEN] = mdt_data_len > lim;
    cfg_err[E_AT_LEN] = at_data_len > lim;
    cfg_err[E_MDT_IDN] = tel_i.list_bad_mdt;
    cfg_err[E_AT_IDN] = tel_i.list_bad_at;
  end

  // ----------------------------------------
  // Cycle timer and telegram supervision
  // ----------------------------------------
  logic [15:0] us_cnt, cyc_us;
  logic [6:0] tick_cnt;
  logic us_tick, cyc_start, mdt_this_cycle;
  logic [1:0] sync_miss;
  assign us_tick = tick_cnt == 7'(CLK_MHZ - 1);
  assign cyc_start = us_tick && cyc_us == comm_cycle_time - 16'h1;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_cnt <= '0;
      cyc_us <= '0;
    end else if (tel_i.sync_seen) begin
      tick_cnt <= '0; // Resync to the master on every sync
      cyc_us <= '0;
    end else begin
      tick_cnt <= us_tick ? 7'h00 : tick_cnt + 7'h01;
      if (us_tick)
        cyc_us <= cyc_start ? 16'h0 : cyc_us + 16'h1;
    end
  end
  assign us_cnt = cyc_us;

  // Strobes at fixed offsets from cycle start are the same in every drive
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_apply_o <= 1'b0;
      fb_sample_o <= 1'b0;
    end else begin
      cmd_apply_o <= us_tick && us_cnt == t3 && phase_reg == 3'h4;
      fb_sample_o <= us_tick && us_cnt == t4 && phase_reg == 3'h4;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_miss <= '0;
      mdt_this_cycle <= 1'b0;
    end else begin
      if (tel_i.sync_seen)
        sync_miss <= '0;
      else if (cyc_start && sync_miss != 2'(SYNC_TIMEOUT_CYCLES_DEF))
        sync_miss <= sync_miss + 2'h1;
      if (tel_i.mdt_seen)
        mdt_this_cycle <= 1'b1;
      else if (tel_i.sync_seen)
        mdt_this_cycle <= 1'b0;
    end
  end

  // ----------------------------------------
  // Phase handling
  // ----------------------------------------
  logic ph_change, ph_up, ph_down, ph_inv;
  assign ph_change = tel_i.sync_seen && tel_i.phase != phase_reg;
  assign ph_up = ph_change && tel_i.phase == phase_reg + 3'h1;
  assign ph_down = ph_change && tel_i.phase < phase_reg;
  assign ph_inv = ph_change && !ph_up && !ph_down && tel_i.phase != 3'h0;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_reg <= 3'h0;
    end else if (ph_down) begin
      phase_reg <= tel_i.phase;
    end else if (ph_up && drive_ready_i && cfg_err == '0) begin
      phase_reg <= tel_i.phase;
    end
  end
  assign phase_o = phase_reg;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      addr_act_reg <= '0;
    else if (ph_up && phase_reg == 3'h0 && drive_ready_i && cfg_err == '0)
      addr_act_reg <= addr_reg;
  end
  assign drive_addr_o = addr_act_reg;

  // ----------------------------------------
  // Sticky errors, set wins over clear
  // ----------------------------------------
  always_comb begin
    err_set = '0;
    if (ph_up)
      err_set[E_RATIO:E_MDT_ODD] = cfg_err[E_RATIO:E_MDT_ODD];
    err_set[E_MDT_LEN] = ph_up && cfg_err[E_MDT_LEN];
    err_set[E_AT_LEN] = ph_up && cfg_err[E_AT_LEN];
    err_set[E_MDT_IDN] = tel_i.list_bad_mdt;
    err_set[E_AT_IDN] = tel_i.list_bad_at;
    err_set[E_SYNC] = cyc_start && sync_miss == 2'(SYNC_TIMEOUT_CYCLES_DEF)
                      && phase_reg != 3'h0;
    err_set[E_RTD] = tel_i.sync_seen && !mdt_this_cycle && phase_reg >= 3'h3;
    err_set[E_PH_INV] = ph_inv;
    err_set[E_PH_UP] = ph_up && cfg_err != '0;
    err_set[E_PH_NRDY] = ph_up && !drive_ready_i;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      err_reg <= '0;
    else if (wr && paddr_i == OFS_ERR)
      err_reg <= (err_reg & ~pwdata_i[ERR_W-1:0]) | err_set;
    else
      err_reg <= err_reg | err_set;
  end

  // ----------------------------------------
  // Baud detection, power, enable
  // ----------------------------------------
  logic rx_d;
  logic [15:0] win_cnt, edge_cnt;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_d <= 1'b0;
      win_cnt <= '0;
      edge_cnt <= '0;
      baud_reg <= BAUD_2;
    end else begin
      rx_d <= rx_i;
      if (win_cnt == BAUD_WIN_CYC - 16'h1) begin
        win_cnt <= '0;
        edge_cnt <= '0;
        if (edge_cnt >= BAUD_TH_16) baud_reg <= BAUD_16;
        else if (edge_cnt >= BAUD_TH_8) baud_reg <= BAUD_8;
        else if (edge_cnt >= BAUD_TH_4) baud_reg <= BAUD_4;
        else if (edge_cnt != 16'h0) baud_reg <= BAUD_2;
      end else begin
        win_cnt <= win_cnt + 16'h1;
        if (rx_i != rx_d) edge_cnt <= edge_cnt + 16'h1;
      end
    end
  end

  logic [7:0] cable_m;
  logic mcw_en_d;
  assign cable_m = ctrl_reg[CTRL_CABLE_LSB +: 8];
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_power_o <= 2'h0;
      mcw_en_d <= 1'b0;
      enable_req_o <= 1'b0;
      distortion_indicator_o <= 1'b0;
    end else begin
      tx_power_o <= cable_m <= 8'h0f ? 2'h0 : cable_m <= 8'h1e ? 2'h1 :
                    cable_m <= 8'h2d ? 2'h2 : 2'h3;
      if (tel_i.mdt_seen) begin
        mcw_en_d <= tel_i.mcw[MCW_ENABLE_BIT];
        enable_req_o <= tel_i.mcw[MCW_ENABLE_BIT] && !mcw_en_d;
      end else begin
        enable_req_o <= 1'b0;
      end
      distortion_indicator_o <= err_reg[E_SYNC];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_odd_len: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ph_up && mdt_len[0] |=> err_reg[E_MDT_ODD]) else $error("odd length not flagged");
  a_short_lim: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ph_up && comm_cycle_time == pos_us && mdt_data_len > MAX_DATA_SHORT |=> err_reg[E_MDT_LEN])
    else $error("limit not 24");
  a_nrdy: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ph_up && !drive_ready_i |=> err_reg[E_PH_NRDY] && $stable(phase_reg))
    else $error("unready switch");
  a_block_adv: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ph_up && cfg_err != '0 |=> phase_reg == $past(phase_reg)) else $error("advance not blocked");
  a_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    err_reg[E_PH_INV] && !(wr && paddr_i == OFS_ERR) |=> err_reg[E_PH_INV])
    else $error("flag lost");
  a_enable_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    enable_req_o |-> $past(tel_i.mdt_seen) && !$past(mcw_en_d)) else $error("bad enable");
  a_addr_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(ph_up && phase_reg == 3'h0) |=> $stable(addr_act_reg)) else $error("address moved");
  a_power_lvl: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    cable_m > 8'h2d ##1 cable_m > 8'h2d |-> tx_power_o == 2'h3) else $error("power level");
  c_advance: cover property (@(posedge clk_i) ph_up ##1 phase_reg == 3'h1);
  c_enable: cover property (@(posedge clk_i) enable_req_o);
  c_sync_fault: cover property (@(posedge clk_i) err_set[E_SYNC]);
endmodule

// ### test/ring_master_model.sv
// Purpose: Behavioural motion master that feeds the ring side of the slave
// Assumes: Receiver output is abstracted to telegram_s event pulses
// Notes: Line toggle rate is set through half, in clock cycles between line toggles
`timescale 1ns/10ps
module ring_master_model import ring_pkg::*; (
  // Clock
  input wire logic clk_i,
  // Ring towards the drive
  output logic rx_o,
  output telegram_s tel_o
);
  // ----------------------------------------
  // Line activity
  // ----------------------------------------
  int half = 63;
  int cnt = 0;

  initial begin
    rx_o = 1'b0;
    tel_o = '0;
  end

  // Runs continuously, since the ring carries traffic in every cycle
  always @(posedge clk_i) begin
    cnt <= (cnt >= half - 1) ? 0 : cnt + 1;
    if (cnt >= half - 1) begin
      rx_o <= ~rx_o;
    end
  end

  // ----------------------------------------
  // Telegrams
  // ----------------------------------------
  // The bench only asks for a phase change once setup writes are done
  task automatic sync(input logic [2:0] ph);
    @(posedge clk_i);
    tel_o.sync_seen <= 1'b1;
    tel_o.phase <= ph;
    @(posedge clk_i);
    tel_o.sync_seen <= 1'b0;
  endtask

  task automatic mdt(input logic [15:0] mcw, input logic bad_m, input logic bad_a);
    @(posedge clk_i);
    tel_o.mdt_seen <= 1'b1;
    tel_o.mcw <= mcw;
    tel_o.list_bad_mdt <= bad_m;
    tel_o.list_bad_at <= bad_a;
    @(posedge clk_i);
    tel_o.mdt_seen <= 1'b0;
    tel_o.list_bad_mdt <= 1'b0;
    tel_o.list_bad_at <= 1'b0;
  endtask
endmodule

// ### test/ring_cyclic_telegram_slave_tb.sv
// Purpose: Self-checking bench for the ring cyclic telegram slave
// Assumes: pready is always high; configuration checks run on a phase advance
// Notes: A two microsecond cycle brings strobes and the sync timeout into a short run
`timescale 1ns/10ps
module ring_cyclic_telegram_slave_tb import ring_pkg::*;;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic drive_ready_i = 1'b1;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, rx_i, cmd_apply_o, fb_sample_o, enable_req_o;
  logic distortion_indicator_o;
  logic [1:0] tx_power_o;
  logic [7:0] drive_addr_o;
  logic [2:0] phase_o;
  telegram_s tel_i;
  logic [31:0] rd;
  logic rd_err;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] cab_len [6] = '{8'h0f, 8'h10, 8'h1e, 8'h1f, 8'h2d, 8'h2e};
  logic [1:0] cab_pow [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
  int half_tbl [4] = '{63, 32, 16, 8};
  logic [7:0] bad_ofs [10] = '{OFS_MDT, OFS_SLOT, OFS_SLOT, OFS_SLOT, OFS_MDT, OFS_MDT,
    OFS_CYCLE, OFS_CYCLE, OFS_LIST, OFS_LIST};
  logic [31:0] bad_val [10] = '{32'h0096_0107, 32'h012c_000a, 32'h0064_00f8, 32'h000b_000a,
    32'h0096_0608, 32'h00f5_0108, 32'h00fa_012c, 32'h02ee_01f4, 32'h0a04_0419, 32'h0a04_1904};
  int bad_bit [10] = '{E_MDT_ODD, E_SLOT, E_MDT_END, E_T3_IN, E_REC, E_T4, E_CYC, E_RATIO,
    E_MDT_LEN, E_AT_LEN};

  always #4 clk_i = ~clk_i;

  ring_master_model m_u (.clk_i, .rx_o(rx_i), .tel_o(tel_i));

  ring_cyclic_telegram_slave dut_u (.clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rx_i, .tel_i, .drive_ready_i,
    .tx_power_o, .drive_addr_o, .phase_o, .cmd_apply_o, .fb_sample_o, .enable_req_o,
    .distortion_indicator_o);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Idle edge after each transfer so psel never gets two updates in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata_o;
    rd_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cfg_good();
    apb(1'b1, OFS_CTRL, 32'h0000_000a);
    apb(1'b1, OFS_CYCLE, 32'h00fa_00fa);
    apb(1'b1, OFS_SLOT, 32'h0064_000a);
    apb(1'b1, OFS_MDT, 32'h0096_0108);
    apb(1'b1, OFS_LIST, 32'h0a04_0404);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, OFS_CYCLE, 32'h0);
    chk("cycle reset", RST_CYCLE, rd);
    apb(1'b0, OFS_ERR, 32'h0);
    chk("error reset", 32'h0, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, 32'(rd_err));
    chk("ready", 32'h1, 32'(pready_o));
    chk("distortion idle", 32'h0, 32'(distortion_indicator_o));
  endtask

  task automatic t_power();
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_CTRL, {24'h0, cab_len[i]});
      cyc(2);
      chk("tx power", {30'h0, cab_pow[i]}, {30'h0, tx_power_o});
    end
  endtask

  task automatic t_baud();
    for (int i = 0; i < 4; i++) begin
      m_u.half <= half_tbl[i];
      cyc(600);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("baud status", 32'(i), {30'h0, rd[1:0]});
    end
  endtask

  // Each case breaks one setting of a valid set, then asks for phase 1
  task automatic t_cfg_errors();
    for (int i = 0; i < 10; i++) begin
      cfg_good();
      apb(1'b1, bad_ofs[i], bad_val[i]);
      apb(1'b1, OFS_ERR, 32'h0001_ffff);
      m_u.sync(3'd1);
      cyc(4);
      apb(1'b0, OFS_ERR, 32'h0);
      chk("config error flag", 32'h1, 32'(rd[bad_bit[i]]));
      chk("advance blocked", 32'h0, {29'h0, phase_o});
      m_u.sync(3'd0);
    end
  endtask

  task automatic t_enable();
    m_u.mdt(16'h0000, 1'b1, 1'b0);
    m_u.mdt(16'h8000, 1'b0, 1'b1);
    @(negedge clk_i);
    chk("enable request", 32'h1, 32'(enable_req_o));
    @(negedge clk_i);
    chk("enable pulse width", 32'h0, 32'(enable_req_o));
    @(posedge clk_i);
    m_u.mdt(16'h8000, 1'b0, 1'b0);
    @(negedge clk_i);
    chk("enable held high", 32'h0, 32'(enable_req_o));
    @(posedge clk_i);
    apb(1'b0, OFS_ERR, 32'h0);
    chk("mdt list flag", 32'h1, 32'(rd[E_MDT_IDN]));
    chk("at list flag", 32'h1, 32'(rd[E_AT_IDN]));
  endtask

  // Runs in phase 4 only, since the strobes are gated by it
  task automatic t_timing();
    int gap;
    apb(1'b1, OFS_SLOT, 32'h0001_0000);
    apb(1'b1, OFS_MDT, 32'h0000_0108);
    apb(1'b1, OFS_CYCLE, 32'h0002_0002);
    m_u.sync(3'd4);
    gap = 0;
    while (cmd_apply_o !== 1'b1 && gap < 400) begin
      @(negedge clk_i);
      gap++;
    end
    chk("apply strobe", 32'h1, 32'(cmd_apply_o));
    gap = 0;
    while (fb_sample_o !== 1'b1 && gap < 400) begin
      @(negedge clk_i);
      gap++;
    end
    chk("apply to sample", 32'(CLK_MHZ), 32'(gap));
    while (cmd_apply_o !== 1'b1 && gap < 400) begin
      @(negedge clk_i);
      gap++;
    end
    chk("apply spacing", 32'(2 * CLK_MHZ), 32'(gap));
    cyc(300);
    chk("distortion on sync loss", 32'h1, 32'(distortion_indicator_o));
    apb(1'b0, OFS_ERR, 32'h0);
    chk("sync loss flag", 32'h1, 32'(rd[E_SYNC]));
    chk("master telegram loss flag", 32'h1, 32'(rd[E_RTD]));
    cfg_good();
    apb(1'b1, OFS_CYCLE, 32'h01f4_01f4);
    apb(1'b1, OFS_LIST, 32'h0a04_3030);
  endtask

  task automatic t_phase_walk();
    cfg_good();
    apb(1'b1, OFS_CYCLE, 32'h01f4_01f4);
    apb(1'b1, OFS_LIST, 32'h0a04_3030);
    apb(1'b1, OFS_ERR, 32'h0001_ffff);
    apb(1'b1, OFS_ADDR, 32'h5);
    chk("address before phase 1", 32'h0, {24'h0, drive_addr_o});
    for (int p = 1; p <= 4; p++) begin
      m_u.sync(3'(p));
      cyc(4);
      chk("phase advance", 32'(p), {29'h0, phase_o});
      chk("active address", 32'h5, {24'h0, drive_addr_o});
      if (p == 1) begin
        apb(1'b1, OFS_ADDR, 32'h9);
      end
    end
    t_timing();
    t_enable();
    m_u.sync(3'd6);
    cyc(4);
    chk("phase after jump", 32'h4, {29'h0, phase_o});
    drive_ready_i <= 1'b0;
    m_u.sync(3'd5);
    cyc(4);
    apb(1'b0, OFS_ERR, 32'h0);
    chk("invalid phase flag", 32'h1, 32'(rd[E_PH_INV]));
    chk("not ready flag", 32'h1, 32'(rd[E_PH_NRDY]));
    chk("phase held", 32'h4, {29'h0, phase_o});
    apb(1'b1, OFS_ERR, 32'h0001_ffff);
    apb(1'b0, OFS_ERR, 32'h0);
    chk("errors cleared", 32'h0, rd);
    drive_ready_i <= 1'b1;
    m_u.sync(3'd0);
    cyc(4);
    chk("phase regression", 32'h0, {29'h0, phase_o});
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_power();
    t_baud();
    t_cfg_errors();
    t_phase_walk();
    end_of_test();
  end

  // Whole run needs about 4000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    $display("Watchdog expired");
    end_of_test();
  end
endmodule
